// [core/ppab_buf_mem.v]
// two-bank sample storage of the acquisition buffer
`timescale 1ns/100ps
module ppab_buf_mem #(
  parameter DATA_W = 16,
  parameter ADDR_W = 8
) (
  input wire clock,
  input wire wr_en,
  input wire wr_bank,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire rd_bank,
  input wire [ADDR_W-1:0] rd_addr,
  output wire [DATA_W-1:0] rd_data
);
  localparam DEPTH = 2 << ADDR_W;

  reg [DATA_W-1:0] mem_r [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem_r[{wr_bank, wr_addr}] <= wr_data;
    end
  end

  assign rd_data = mem_r[{rd_bank, rd_addr}];
endmodule // ppab_buf_mem

// [core/ppab_defs.vh]
// constants of the ping-pong acquisition buffer
`ifndef PPAB_DEFS_VH
`define PPAB_DEFS_VH
// register byte offsets
`define PPAB_CTRL 8'h00
`define PPAB_NCHAN 8'h04
`define PPAB_NSAMP 8'h08
`define PPAB_NCOUNT 8'h0c
`define PPAB_READY 8'h10
`define PPAB_FETCH 8'h14
`define PPAB_DATA 8'h18
`define PPAB_SCAN_IDX 8'h1c
`define PPAB_SCAN_DAT 8'h20
`define PPAB_INT_STAT 8'h24
`define PPAB_INT_MASK 8'h28
// command bits of the control register
`define PPAB_CMD_START 0
`define PPAB_CMD_STOP 1
`define PPAB_CMD_CLR 2
`define PPAB_CMD_INIT 3
// interrupt status bits
`define PPAB_INT_FULL 0
`define PPAB_INT_OVR 1
`define PPAB_INT_DONE 2
`define PPAB_INT_W 3
// reset values and the channel limit
`define PPAB_NCHAN_RST 7'h01
`define PPAB_NSAMP_RST 16'h0001
`define PPAB_NCOUNT_RST 16'h0000
`define PPAB_RDY_NONE 2'h0
`define PPAB_MAX_CHAN 7'h40
`endif

// [core/ppab_top.v]
// ping-pong acquisition buffer with apb registers
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "ppab_defs.vh"
module ppab_top #(
  parameter ADDR_W = 8
) (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg conv_req,
  output reg [5:0] conv_chan,
  input wire conv_valid,
  input wire [15:0] conv_data,
  output reg irq
);
  localparam [ADDR_W-1:0] LAST_MAX = {ADDR_W{1'b1}};
  localparam [22:0] DEPTH = 23'h000001 << ADDR_W;

  // 1-based buffer id as shown to software
  function [1:0] bank_id;
    input bank;
    begin
      bank_id = bank ? 2'h2 : 2'h1;
    end
  endfunction

  // ready code from the full flags and the older bank
  function [1:0] ready_code;
    input [1:0] full;
    input oldest;
    begin
      case (full)
        2'b00: ready_code = `PPAB_RDY_NONE;
        2'b01: ready_code = bank_id(1'b0);
        2'b10: ready_code = bank_id(1'b1);
        default: ready_code = bank_id(oldest);
      endcase
    end
  endfunction

  reg running_r;
  reg [6:0] nchan_r;
  reg [15:0] nsamp_r;
  reg [15:0] ncount_r;
  reg [5:0] scan_idx_r;
  reg [5:0] scan_list_r [0:63];
  reg [5:0] scan_pos_r;
  reg [15:0] dec_cnt_r;
  reg keep_r;
  reg blk_r;
  reg busy_r;
  reg wr_bank_r;
  reg [ADDR_W-1:0] wr_ptr_r;
  reg [1:0] full_r;
  reg [1:0] full_nxt;
  reg oldest_r;
  reg oldest_nxt;
  reg [1:0] ready_r;
  reg [1:0] ready_nxt;
  reg fetch_act_r;
  reg fetch_bank_r;
  reg [ADDR_W-1:0] rd_ptr_r;
  reg [`PPAB_INT_W-1:0] int_stat_r;
  reg [`PPAB_INT_W-1:0] int_mask_r;
  reg [`PPAB_INT_W-1:0] int_stat_nxt;
  reg [31:0] rdata_nxt;
  reg rerr_nxt;

  wire [15:0] mem_rd;
  wire [22:0] buf_len;
  wire [ADDR_W-1:0] last_idx;
  wire setup_ph;
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire ctrl_wr;
  wire start_cmd;
  wire stop_cmd;
  wire clr_cmd;
  wire init_cmd;
  wire fetch_wr;
  wire [1:0] fetch_id;
  wire fetch_ok;
  wire data_rd;
  wire last_rd;
  wire smp;
  wire store;
  wire drop;
  wire buf_done;
  wire scan_end;
  wire [15:0] dec_nxt;
  wire wr_bank_nxt;
  wire [`PPAB_INT_W-1:0] int_set;
  wire [`PPAB_INT_W-1:0] int_clr;

  // words per buffer, capped by the bank depth
  assign buf_len = nchan_r * nsamp_r;
  assign last_idx = (buf_len > DEPTH) ? LAST_MAX :
                    buf_len[ADDR_W-1:0] + LAST_MAX; // minus one, wraps at a full bank

  // apb phases; writes and read side effects act at the access edge
  assign setup_ph = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;

  assign ctrl_wr = wr_acc & (paddr == `PPAB_CTRL);
  assign start_cmd = ctrl_wr & pwdata[`PPAB_CMD_START];
  assign stop_cmd = ctrl_wr & pwdata[`PPAB_CMD_STOP];
  assign clr_cmd = ctrl_wr & pwdata[`PPAB_CMD_CLR];
  assign init_cmd = ctrl_wr & pwdata[`PPAB_CMD_INIT];

  // fetch only names a buffer that really holds data
  assign fetch_wr = wr_acc & (paddr == `PPAB_FETCH);
  assign fetch_id = pwdata[1:0];
  assign fetch_ok = fetch_wr & (fetch_id != `PPAB_RDY_NONE) &
                    full_r[fetch_id == 2'h2];
  assign data_rd = rd_acc & (paddr == `PPAB_DATA) & fetch_act_r;
  assign last_rd = data_rd & (rd_ptr_r == last_idx);

  // conversion results and where they go
  assign smp = running_r & busy_r & conv_valid;
  assign store = smp & keep_r & ~blk_r & ~(start_cmd | init_cmd);
  assign drop = smp & keep_r & blk_r;
  assign buf_done = store & (wr_ptr_r == last_idx);
  assign scan_end = smp & ({1'b0, scan_pos_r} == nchan_r - 7'h01);
  assign dec_nxt = (dec_cnt_r == ncount_r) ? 16'h0000 :
                   dec_cnt_r + 16'h0001;
  assign wr_bank_nxt = buf_done ? ~wr_bank_r : wr_bank_r;

  assign int_set = {last_rd, drop, buf_done};
  assign int_clr = (wr_acc & (paddr == `PPAB_INT_STAT)) ?
                   pwdata[`PPAB_INT_W-1:0] : {`PPAB_INT_W{1'b0}};

  ppab_buf_mem #(
    .DATA_W(16),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clock(clock),
    .wr_en(store),
    .wr_bank(wr_bank_r),
    .wr_addr(wr_ptr_r),
    .wr_data(conv_data),
    .rd_bank(fetch_bank_r),
    .rd_addr(rd_ptr_r),
    .rd_data(mem_rd)
  );

  // buffer ownership and ready code
  always @* begin
    full_nxt = full_r;
    oldest_nxt = oldest_r;
    if (last_rd) begin
      full_nxt[fetch_bank_r] = 1'b0;
      oldest_nxt = ~fetch_bank_r;
    end
    if (clr_cmd | init_cmd) begin
      full_nxt = 2'b00;
    end
    if (buf_done) begin
      full_nxt[wr_bank_r] = 1'b1;
      if (!full_nxt[~wr_bank_r]) begin
        oldest_nxt = wr_bank_r;
      end
    end
    ready_nxt = ready_code(full_nxt, oldest_nxt);
  end

  // set wins over a write-one clear
  always @* begin
    int_stat_nxt = (int_stat_r & ~int_clr) | int_set;
  end

  // read data prepared in the setup phase
  always @* begin
    rdata_nxt = 32'h00000000;
    rerr_nxt = 1'b0;
    case (paddr)
      `PPAB_CTRL: rdata_nxt = {31'h00000000, running_r};
      `PPAB_NCHAN: rdata_nxt = {25'h0000000, nchan_r};
      `PPAB_NSAMP: rdata_nxt = {16'h0000, nsamp_r};
      `PPAB_NCOUNT: rdata_nxt = {16'h0000, ncount_r};
      `PPAB_READY: rdata_nxt = {30'h00000000, ready_r};
      `PPAB_FETCH: begin
        rdata_nxt = {29'h00000000, fetch_act_r,
                     fetch_act_r ? bank_id(fetch_bank_r) : 2'h0};
      end
      `PPAB_DATA: begin
        if (fetch_act_r) begin
          rdata_nxt = {{16{mem_rd[15]}}, mem_rd};
        end
      end
      `PPAB_SCAN_IDX: rdata_nxt = {26'h0000000, scan_idx_r};
      `PPAB_SCAN_DAT: begin
        rdata_nxt = {26'h0000000, scan_list_r[scan_idx_r]};
      end
      `PPAB_INT_STAT: rdata_nxt = {29'h00000000, int_stat_r};
      `PPAB_INT_MASK: rdata_nxt = {29'h00000000, int_mask_r};
      default: rerr_nxt = 1'b1;
    endcase
  end

  // apb answer: zero wait states
  always @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & rerr_nxt;
      if (setup_ph & ~pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // configuration registers
  always @(posedge clock) begin
    if (reset) begin
      nchan_r <= `PPAB_NCHAN_RST;
      nsamp_r <= `PPAB_NSAMP_RST;
      ncount_r <= `PPAB_NCOUNT_RST;
      scan_idx_r <= 6'h00;
      int_mask_r <= {`PPAB_INT_W{1'b0}};
    end else if (wr_acc) begin
      case (paddr)
        `PPAB_NCHAN: begin
          if (pwdata[6:0] != 7'h00 && pwdata[6:0] <= `PPAB_MAX_CHAN) begin
            nchan_r <= pwdata[6:0];
          end
        end
        `PPAB_NSAMP: begin
          if (pwdata[15:0] != 16'h0000) begin
            nsamp_r <= pwdata[15:0];
          end
        end
        `PPAB_NCOUNT: ncount_r <= pwdata[15:0];
        `PPAB_SCAN_IDX: scan_idx_r <= pwdata[5:0];
        `PPAB_SCAN_DAT: scan_idx_r <= scan_idx_r + 6'h01;
        `PPAB_INT_MASK: int_mask_r <= pwdata[`PPAB_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // channel list storage
  always @(posedge clock) begin
    if (wr_acc && paddr == `PPAB_SCAN_DAT) begin
      scan_list_r[scan_idx_r] <= pwdata[5:0];
    end
  end

  // sampling sequencer
  always @(posedge clock) begin
    if (reset) begin
      running_r <= 1'b0;
      busy_r <= 1'b0;
      conv_req <= 1'b0;
      conv_chan <= 6'h00;
      scan_pos_r <= 6'h00;
      dec_cnt_r <= 16'h0000;
      keep_r <= 1'b1;
      blk_r <= 1'b0;
    end else if (stop_cmd | init_cmd) begin
      running_r <= 1'b0;
      busy_r <= 1'b0;
      conv_req <= 1'b0;
    end else if (start_cmd) begin
      running_r <= 1'b1;
      busy_r <= 1'b0;
      conv_req <= 1'b0;
      scan_pos_r <= 6'h00;
      dec_cnt_r <= 16'h0000;
      keep_r <= 1'b1;
      blk_r <= full_r[wr_bank_r];
    end else if (running_r) begin
      // free-running until stopped
      conv_req <= 1'b0;
      if (!busy_r) begin
        conv_req <= 1'b1;
        conv_chan <= scan_list_r[scan_pos_r];
        busy_r <= 1'b1;
      end else if (smp) begin
        busy_r <= 1'b0;
        if (scan_end) begin
          scan_pos_r <= 6'h00;
          dec_cnt_r <= dec_nxt;
          keep_r <= (dec_nxt == 16'h0000);
          blk_r <= full_nxt[wr_bank_nxt];
        end else begin
          scan_pos_r <= scan_pos_r + 6'h01;
        end
      end
    end else begin
      conv_req <= 1'b0;
      busy_r <= 1'b0;
    end
  end

  // write side of the ping-pong pair
  always @(posedge clock) begin
    if (reset) begin
      wr_bank_r <= 1'b0;
      wr_ptr_r <= {ADDR_W{1'b0}};
    end else if (init_cmd | start_cmd) begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      if (init_cmd) begin
        wr_bank_r <= 1'b0;
      end
    end else if (buf_done) begin
      wr_bank_r <= ~wr_bank_r;
      wr_ptr_r <= {ADDR_W{1'b0}};
    end else if (store) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // flags, transfer side and interrupt
  always @(posedge clock) begin
    if (reset) begin
      full_r <= 2'b00;
      oldest_r <= 1'b0;
      ready_r <= `PPAB_RDY_NONE;
      fetch_act_r <= 1'b0;
      fetch_bank_r <= 1'b0;
      rd_ptr_r <= {ADDR_W{1'b0}};
      int_stat_r <= {`PPAB_INT_W{1'b0}};
      irq <= 1'b0;
    end else begin
      full_r <= full_nxt;
      oldest_r <= oldest_nxt;
      ready_r <= ready_nxt;
      int_stat_r <= int_stat_nxt;
      irq <= |(int_stat_nxt & int_mask_r);
      if (clr_cmd | init_cmd | last_rd) begin
        fetch_act_r <= 1'b0;
      end else if (fetch_ok) begin
        fetch_act_r <= 1'b1;
        fetch_bank_r <= (fetch_id == 2'h2);
        rd_ptr_r <= {ADDR_W{1'b0}};
      end else if (data_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // ppab_top

// [verif/ppab_conv_model.sv]
// converter model answering sample requests
`timescale 1ns/100ps
module ppab_conv_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic conv_req,
  input wire logic [5:0] conv_chan,
  input wire logic [3:0] lat,
  output logic conv_valid,
  output logic [15:0] conv_data
);
  logic busy;
  logic [3:0] wait_r;
  logic [9:0] n_conv;
  always @(posedge clock) begin
    conv_valid <= 1'b0;
    // data line toggles outside a result
    conv_data <= ~conv_data;
    if (reset) begin
      busy <= 1'b0;
      n_conv <= 10'h000;
      conv_data <= 16'h0000;
    end else if (conv_req) begin
      busy <= 1'b1;
      wait_r <= lat;
    end else if (busy && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      conv_valid <= 1'b1;
      conv_data <= {conv_chan, n_conv};
      n_conv <= n_conv + 10'h001;
    end
  end
endmodule // ppab_conv_model

// [verif/ppab_top_chk.sv]
// port checker of the ping-pong acquisition buffer
`timescale 1ns/100ps
`include "ppab_defs.vh"
module ppab_top_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_req,
  input wire logic [5:0] conv_chan,
  input wire logic conv_valid,
  input wire logic irq
);
  logic run_q;
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == `PPAB_CTRL;
  wire mask_clr = psel && penable && pready && pwrite && paddr == `PPAB_INT_MASK
    && pwdata[2:0] == 3'h0;
  // shadow of the running state seen from control writes
  always_ff @(posedge clock) begin
    if (reset)
      run_q <= 1'b0;
    else if (ctrl_wr && (pwdata[`PPAB_CMD_STOP] || pwdata[`PPAB_CMD_INIT]))
      run_q <= 1'b0;
    else if (ctrl_wr && pwdata[`PPAB_CMD_START])
      run_q <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_req_run; conv_req |-> run_q || $past(run_q); endproperty
  a_req_run: assert property (p_req_run)
    else $error("conversion requested while halted");
  property p_next_req;
    conv_valid && run_q && !ctrl_wr ##1 !ctrl_wr |=> conv_req;
  endproperty
  a_next_req: assert property (p_next_req)
    else $error("no request after a result");
  property p_req_pulse; conv_req |=> !conv_req; endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  property p_chan_stable; conv_chan != $past(conv_chan) |-> conv_req; endproperty
  a_chan_stable: assert property (p_chan_stable)
    else $error("channel changed without request");
  property p_ready_ans; psel && !penable |=> pready; endproperty
  a_ready_ans: assert property (p_ready_ans)
    else $error("no ready in access cycle");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error outside an access");
  property p_unmapped; psel && !penable && paddr == 8'h2c |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_irq_mask; mask_clr |=> ##1 !irq; endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt high with all masked");
  c_result: cover property (conv_valid ##1 conv_req);
  c_err: cover property (pslverr);
  c_irq: cover property ($fell(irq));
endmodule // ppab_top_chk

// [verif/tb_pingpong_acq_buffer.sv]
// self-checking bench of the ping-pong acquisition buffer
`timescale 1ns/100ps
`include "ppab_defs.vh"
module tb_pingpong_acq_buffer;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, conv_req, conv_valid, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] conv_chan;
  logic [5:0] sl [0:2];
  logic [15:0] conv_data;
  logic [3:0] lat;
  int n_errors, samples_checked, cyc, base;
  ppab_top u_ppab_top (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_valid(conv_valid), .conv_data(conv_data), .irq(irq));
  ppab_conv_model u_ppab_conv_model (.clock(clock), .reset(reset), .conv_req(conv_req),
    .conv_chan(conv_chan), .lat(lat), .conv_valid(conv_valid), .conv_data(conv_data));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // timer-tick style polling until a masked bit shows
  task poll(input logic [7:0] a, input logic [31:0] m);
    rd = 32'h0;
    for (int i = 0; i < 300 && (rd & m) == 32'h0; i++) begin
      repeat (4) @(posedge clock);
      apb(1'b0, a, 32'h0);
    end
    chk({31'h0, (rd & m) != 32'h0}, 32'h1);
  endtask
  task readbuf(input logic [1:0] id, input int first, input int nc, input int ns, input int st);
    logic [15:0] s;
    apb(1'b1, `PPAB_FETCH, {30'h0, id});
    for (int n = 0; n < ns; n++)
      for (int c = 0; c < nc; c++) begin
        s = {sl[c], 10'(first + n * st + c)};
        rdc(`PPAB_DATA, {{16{s[15]}}, s});
      end
  endtask
  task cfg(input int nc, input int ns, input int nk);
    apb(1'b1, `PPAB_CTRL, 32'h8);
    repeat (20) @(posedge clock);
    apb(1'b1, `PPAB_NCHAN, nc);
    apb(1'b1, `PPAB_NSAMP, ns);
    apb(1'b1, `PPAB_NCOUNT, nk);
    apb(1'b1, `PPAB_SCAN_IDX, 32'h0);
    for (int c = 0; c < nc; c++) apb(1'b1, `PPAB_SCAN_DAT, {26'h0, sl[c]});
    rdc(`PPAB_READY, 32'h0);
    apb(1'b1, `PPAB_CTRL, 32'h1);
    base = u_ppab_conv_model.n_conv;
  endtask
  task t_regs;
    int k;
    rdc(`PPAB_NCHAN, 32'h1);
    rdc(`PPAB_NSAMP, 32'h1);
    rdc(`PPAB_NCOUNT, 32'h0);
    rdc(`PPAB_INT_MASK, 32'h0);
    rdc(8'h2c, 32'h0);
    chk(err, 1'b1);
    k = 0;
    repeat (20) begin
      @(posedge clock);
      if (conv_req !== 1'b0) k++;
    end
    chk(k, 0);
    apb(1'b1, `PPAB_NCHAN, 32'h0);
    apb(1'b1, `PPAB_NCHAN, 32'h41);
    rdc(`PPAB_NCHAN, 32'h1);
    apb(1'b1, `PPAB_NCHAN, 32'h40);
    rdc(`PPAB_NCHAN, 32'h40);
  endtask
  task t_pingpong;
    int k;
    lat <= 4'h4;
    sl[0] = 6'h21;
    sl[1] = 6'h01;
    sl[2] = 6'h03;
    cfg(3, 2, 0);
    rdc(`PPAB_CTRL, 32'h1);
    apb(1'b1, `PPAB_INT_MASK, 32'h1);
    poll(`PPAB_READY, 32'h3);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, `PPAB_INT_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    apb(1'b1, `PPAB_INT_MASK, 32'h0);
    poll(`PPAB_INT_STAT, 32'h2);
    rdc(`PPAB_READY, 32'h1);
    readbuf(2'h1, base, 3, 2, 3);
    rdc(`PPAB_READY, 32'h2);
    rdc(`PPAB_INT_STAT, 32'h7);
    readbuf(2'h2, base + 6, 3, 2, 3);
    poll(`PPAB_READY, 32'h3);
    apb(1'b1, `PPAB_CTRL, 32'h4);
    rdc(`PPAB_READY, 32'h0);
    apb(1'b1, `PPAB_CTRL, 32'h2);
    rdc(`PPAB_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    k = 0;
    repeat (30) begin
      @(posedge clock);
      if (conv_req !== 1'b0) k++;
    end
    chk(k, 0);
  endtask
  task t_decim;
    lat <= 4'h0;
    sl[0] = 6'h07;
    cfg(1, 2, 1);
    poll(`PPAB_READY, 32'h3);
    chk(rd, 32'h1);
    readbuf(2'h1, base, 1, 2, 2);
    apb(1'b1, `PPAB_CTRL, 32'h2);
  endtask
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h4;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_pingpong;
    t_decim;
    conclude;
  end
endmodule // tb_pingpong_acq_buffer
bind ppab_top ppab_top_chk u_ppab_top_chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .conv_req(conv_req), .conv_chan(conv_chan), .conv_valid(conv_valid),
  .irq(irq));
